// [core/pds_pkg.sv]
/*
 * Shared constants and carrier types for the preamble detector and sync-search sequencer.
 * Assumes a single 100 MHz clock and a 32-bit AXI4-Lite register bus on the host side.
 */
package pds_pkg;

   localparam int unsigned  DATA_W          = 32;
   localparam int unsigned  ADDR_W          = 12;

   // Register indices; byte address is four times the index.
   localparam logic [7:0]   IDX_HDR_CTRL_B  = 8'h33;
   localparam logic [7:0]   IDX_PRE_LEN     = 8'h34;
   localparam logic [7:0]   IDX_PRE_DET_A   = 8'h35;
   localparam logic [7:0]   IDX_SYNC_WORD   = 8'h36;
   localparam logic [7:0]   IDX_IRQ_STATUS  = 8'h40;
   localparam logic [7:0]   IDX_IRQ_MASK    = 8'h41;
   localparam logic [7:0]   IDX_CONTROL     = 8'h42;
   localparam logic [7:0]   IDX_SEQ_STATE   = 8'h43;

   // Field positions.
   localparam int unsigned  SYNCLEN_LSB     = 1;
   localparam int unsigned  PREATH_LSB      = 3;
   localparam int unsigned  CTRL_RX_EN      = 0;
   localparam int unsigned  CTRL_PIN_LSB    = 1;
   localparam int unsigned  IRQ_PRE_DET     = 0;
   localparam int unsigned  IRQ_SYNC_OK     = 1;
   localparam int unsigned  IRQ_SYNC_TMO    = 2;
   localparam int unsigned  IRQ_W           = 3;

   // Reset values.
   localparam logic [7:0]   RST_HDR_CTRL_B  = 8'h02;
   localparam logic [7:0]   RST_PRE_LEN     = 8'h08;
   localparam logic [7:0]   RST_PRE_DET_A   = 8'h28;
   localparam logic [31:0]  RST_SYNC_WORD   = 32'h2dd4_0000;

   // Timing, in received bit periods, and pin-select codes.
   localparam logic [5:0]   TMO_EXTRA_BITS  = 6'h04;
   localparam logic [1:0]   PIN_SEL_LOW     = 2'h0;
   localparam logic [1:0]   PIN_SEL_PRE_DET = 2'h1;
   localparam logic [1:0]   PIN_SEL_SYNC_OK = 2'h2;

   localparam logic [1:0]   RESP_OKAY       = 2'h0;
   localparam logic [1:0]   RESP_SLVERR     = 2'h2;

   typedef struct packed {
      logic [1:0] synclen;
      logic [4:0] preath;
      logic [7:0] prealen;
      logic       rx_en;
      logic [1:0] pin_sel;
   } pds_cfg_t;

   typedef struct packed {
      logic sync_tmo;
      logic sync_ok;
      logic pre_det;
   } pds_evt_t;

endpackage : pds_pkg

// [core/pds_preamble_sync.sv]
/*
 * Preamble detector and sync-word search sequencer with its AXI4-Lite register file.
 * Assumes I_RX_BIT is valid whenever the demodulator pulses I_RX_BIT_VALID for one cycle,
 * and that all inputs are synchronous to I_MCLK.
 */
// Register access over AXI4-Lite was left to the implementer.
module pds_preamble_sync
   import pds_pkg::*;
(
   input  wire logic                I_MCLK,
   input  wire logic                I_RESETN,
   input  wire logic                I_RX_BIT,
   input  wire logic                I_RX_BIT_VALID,
   input  wire logic                S_AXI_AWVALID,
   output logic                     S_AXI_AWREADY,
   input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR,
   input  wire logic                S_AXI_WVALID,
   output logic                     S_AXI_WREADY,
   input  wire logic [DATA_W-1:0]   S_AXI_WDATA,
   input  wire logic [3:0]          S_AXI_WSTRB,
   output logic                     S_AXI_BVALID,
   input  wire logic                S_AXI_BREADY,
   output logic [1:0]               S_AXI_BRESP,
   input  wire logic                S_AXI_ARVALID,
   output logic                     S_AXI_ARREADY,
   input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR,
   output logic                     S_AXI_RVALID,
   input  wire logic                S_AXI_RREADY,
   output logic [DATA_W-1:0]        S_AXI_RDATA,
   output logic [1:0]               S_AXI_RRESP,
   output logic [7:0]               O_TX_PREAMBLE_LEN,
   output logic                     O_GPIO,
   output logic                     O_IRQ
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PRE_SEARCH,
      ST_PRE_HOLD,
      ST_SYNC_SEARCH
   } pds_state_t;

   // Word index of a byte address; low two bits are ignored.
   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] w;
      w = addr >> 2;
      reg_index = w[7:0];
   endfunction : reg_index

   function automatic logic mapped(input logic [7:0] idx, input logic [ADDR_W-1:0] addr);
      mapped = (addr[ADDR_W-1:10] == '0) &&
               (idx == IDX_HDR_CTRL_B || idx == IDX_PRE_LEN || idx == IDX_PRE_DET_A ||
                idx == IDX_SYNC_WORD || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK ||
                idx == IDX_CONTROL || idx == IDX_SEQ_STATE);
   endfunction : mapped

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction : merge

   // Sync mask for the expected bytes; the most significant byte is expected first.
   function automatic logic [31:0] sync_mask(input logic [1:0] len);
      unique case (len)
         2'h0:    sync_mask = 32'h0000_00ff;
         2'h1:    sync_mask = 32'h0000_ffff;
         2'h2:    sync_mask = 32'h00ff_ffff;
         default: sync_mask = 32'hffff_ffff;
      endcase
   endfunction : sync_mask

   // Bus and register state.
   logic              awready_q, awready_d;
   logic              wready_q, wready_d;
   logic              aw_got_q, aw_got_d;
   logic              w_got_q, w_got_d;
   logic [7:0]        aw_idx_q, aw_idx_d;
   logic              aw_ok_q, aw_ok_d;
   logic [31:0]       wdata_q, wdata_d;
   logic [3:0]        wstrb_q, wstrb_d;
   logic              bvalid_q, bvalid_d;
   logic [1:0]        bresp_q, bresp_d;
   logic              arready_q, arready_d;
   logic              rvalid_q, rvalid_d;
   logic [31:0]       rdata_q, rdata_d;
   logic [1:0]        rresp_q, rresp_d;
   logic [7:0]        hdr_ctrl_q, hdr_ctrl_d;
   logic [7:0]        pre_len_q, pre_len_d;
   logic [7:0]        pre_det_a_q, pre_det_a_d;
   logic [31:0]       sync_word_q, sync_word_d;
   logic [IRQ_W-1:0]  irq_stat_q, irq_stat_d;
   logic [IRQ_W-1:0]  irq_mask_q, irq_mask_d;
   logic [2:0]        control_q, control_d;
   logic              irq_q, irq_d;

   // Detector state.
   pds_state_t        state_q, state_d;
   logic              prev_bit_q, prev_bit_d;
   logic [7:0]        run_q, run_d;
   logic [31:0]       shift_q, shift_d;
   logic [5:0]        tmo_cnt_q, tmo_cnt_d;
   logic              gpio_q, gpio_d;
   pds_evt_t          evt;
   pds_cfg_t          cfg;

   assign cfg.synclen = hdr_ctrl_q[SYNCLEN_LSB +: 2];
   assign cfg.preath  = pre_det_a_q[PREATH_LSB +: 5];
   assign cfg.prealen = pre_len_q;
   assign cfg.rx_en   = control_q[CTRL_RX_EN];
   assign cfg.pin_sel = control_q[CTRL_PIN_LSB +: 2];

   always_comb begin
      logic [7:0]  thr;
      logic [5:0]  tmo_len;
      logic        alt;
      logic        match;
      thr       = {1'b0, cfg.preath, 2'b00};
      if (cfg.preath == 5'h00) begin
         thr = 8'h04;
      end
      tmo_len   = {1'b0, cfg.synclen, 3'b000} + 6'h08 + TMO_EXTRA_BITS;
      alt       = I_RX_BIT != prev_bit_q;
      state_d   = state_q;
      prev_bit_d = prev_bit_q;
      run_d     = run_q;
      shift_d   = shift_q;
      tmo_cnt_d = tmo_cnt_q;
      evt       = '0;
      match     = 1'b0;
      if (I_RX_BIT_VALID) begin
         prev_bit_d = I_RX_BIT;
         shift_d    = {shift_q[30:0], I_RX_BIT};
         run_d      = alt ? ((run_q == 8'hff) ? run_q : run_q + 8'h01) : 8'h01;
         match      = ((shift_d ^ (sync_word_q >> {~cfg.synclen, 3'b000})) &
                       sync_mask(cfg.synclen)) == 32'h0;
      end
      unique case (state_q)
         ST_IDLE: begin
            run_d = 8'h00;
            if (cfg.rx_en) begin
               state_d = ST_PRE_SEARCH;
            end
         end
         ST_PRE_SEARCH: begin
            if (I_RX_BIT_VALID && run_d >= thr) begin
               evt.pre_det = 1'b1;
               state_d     = ST_PRE_HOLD;
            end
         end
         ST_PRE_HOLD: begin
            if (I_RX_BIT_VALID && match) begin
               evt.sync_ok = 1'b1;
               state_d     = ST_PRE_SEARCH;
               run_d       = 8'h00;
            end else if (I_RX_BIT_VALID && !alt) begin
               state_d   = ST_SYNC_SEARCH;
               tmo_cnt_d = 6'h01;
            end
         end
         ST_SYNC_SEARCH: begin
            if (I_RX_BIT_VALID) begin
               if (match) begin
                  evt.sync_ok = 1'b1;
                  state_d     = ST_PRE_SEARCH;
                  run_d       = 8'h00;
               end else if (tmo_cnt_q + 6'h01 >= tmo_len) begin
                  evt.sync_tmo = 1'b1;
                  state_d      = ST_PRE_SEARCH;
                  run_d        = 8'h00;
               end else begin
                  tmo_cnt_d = tmo_cnt_q + 6'h01;
               end
            end
         end
      endcase
      if (!cfg.rx_en) begin
         state_d = ST_IDLE;
      end
      unique case (cfg.pin_sel)
         PIN_SEL_PRE_DET: gpio_d = (state_d == ST_PRE_HOLD) || (state_d == ST_SYNC_SEARCH);
         PIN_SEL_SYNC_OK: gpio_d = evt.sync_ok;
         default:         gpio_d = 1'b0;
      endcase
   end

   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state_q    <= ST_IDLE;
         prev_bit_q <= 1'b0;
         run_q      <= 8'h00;
         shift_q    <= 32'h0;
         tmo_cnt_q  <= 6'h00;
         gpio_q     <= 1'b0;
      end else begin
         state_q    <= state_d;
         prev_bit_q <= prev_bit_d;
         run_q      <= run_d;
         shift_q    <= shift_d;
         tmo_cnt_q  <= tmo_cnt_d;
         gpio_q     <= gpio_d;
      end
   end

   always_comb begin
      logic        have_aw;
      logic        have_w;
      logic [7:0]  idx;
      logic [7:0]  ridx;
      logic [31:0] wd;
      logic [IRQ_W-1:0] w1c;
      ridx        = reg_index(S_AXI_ARADDR);
      have_aw     = aw_got_q || (S_AXI_AWVALID && awready_q);
      have_w      = w_got_q || (S_AXI_WVALID && wready_q);
      aw_got_d    = have_aw;
      w_got_d     = have_w;
      aw_idx_d    = (S_AXI_AWVALID && awready_q) ? reg_index(S_AXI_AWADDR) : aw_idx_q;
      aw_ok_d     = (S_AXI_AWVALID && awready_q) ? mapped(reg_index(S_AXI_AWADDR), S_AXI_AWADDR) : aw_ok_q;
      wdata_d     = (S_AXI_WVALID && wready_q) ? S_AXI_WDATA : wdata_q;
      wstrb_d     = (S_AXI_WVALID && wready_q) ? S_AXI_WSTRB : wstrb_q;
      bvalid_d    = bvalid_q && !S_AXI_BREADY;
      bresp_d     = bresp_q;
      hdr_ctrl_d  = hdr_ctrl_q;
      pre_len_d   = pre_len_q;
      pre_det_a_d = pre_det_a_q;
      sync_word_d = sync_word_q;
      irq_mask_d  = irq_mask_q;
      control_d   = control_q;
      w1c         = '0;
      idx         = aw_idx_d;
      wd          = '0;
      if (have_aw && have_w && !bvalid_q) begin
         aw_got_d = 1'b0;
         w_got_d  = 1'b0;
         bvalid_d = 1'b1;
         bresp_d  = aw_ok_d ? RESP_OKAY : RESP_SLVERR;
         if (aw_ok_d) begin
            unique case (idx)
               IDX_HDR_CTRL_B: begin
                  wd = merge({24'h0, hdr_ctrl_q}, wdata_d, wstrb_d);
                  hdr_ctrl_d = wd[7:0];
               end
               IDX_PRE_LEN: begin
                  wd = merge({24'h0, pre_len_q}, wdata_d, wstrb_d);
                  pre_len_d = wd[7:0];
               end
               IDX_PRE_DET_A: begin
                  wd = merge({24'h0, pre_det_a_q}, wdata_d, wstrb_d);
                  pre_det_a_d = wd[7:0];
               end
               IDX_SYNC_WORD:  sync_word_d = merge(sync_word_q, wdata_d, wstrb_d);
               IDX_IRQ_STATUS: w1c = wstrb_d[0] ? wdata_d[IRQ_W-1:0] : '0;
               IDX_IRQ_MASK: begin
                  wd = merge({29'h0, irq_mask_q}, wdata_d, wstrb_d);
                  irq_mask_d = wd[IRQ_W-1:0];
               end
               IDX_CONTROL: begin
                  wd = merge({29'h0, control_q}, wdata_d, wstrb_d);
                  control_d = wd[2:0];
               end
               default: ;
            endcase
         end
      end
      awready_d = !aw_got_d && !bvalid_d;
      wready_d  = !w_got_d && !bvalid_d;
      // A new event beats a clear that lands in the same cycle.
      irq_stat_d = (irq_stat_q & ~w1c) | {evt.sync_tmo, evt.sync_ok, evt.pre_det};
      irq_d      = |(irq_stat_d & irq_mask_d);
      rvalid_d   = rvalid_q && !S_AXI_RREADY;
      arready_d  = !rvalid_d;
      rdata_d    = rdata_q;
      rresp_d    = rresp_q;
      if (S_AXI_ARVALID && arready_q) begin
         rvalid_d  = 1'b1;
         arready_d = 1'b0;
         rresp_d   = mapped(ridx, S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
         unique case (ridx)
            IDX_HDR_CTRL_B: rdata_d = {24'h0, hdr_ctrl_q};
            IDX_PRE_LEN:    rdata_d = {24'h0, pre_len_q};
            IDX_PRE_DET_A:  rdata_d = {24'h0, pre_det_a_q};
            IDX_SYNC_WORD:  rdata_d = sync_word_q;
            IDX_IRQ_STATUS: rdata_d = {29'h0, irq_stat_q};
            IDX_IRQ_MASK:   rdata_d = {29'h0, irq_mask_q};
            IDX_CONTROL:    rdata_d = {29'h0, control_q};
            IDX_SEQ_STATE:  rdata_d = {18'h0, tmo_cnt_q, run_q};
            default:        rdata_d = 32'h0;
         endcase
         if (ridx == IDX_SEQ_STATE) begin
            rdata_d[31:30] = state_q;
         end
         if (!mapped(ridx, S_AXI_ARADDR)) begin
            rdata_d = 32'h0;
         end
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         awready_q   <= 1'b0;
         wready_q    <= 1'b0;
         aw_got_q    <= 1'b0;
         w_got_q     <= 1'b0;
         aw_idx_q    <= 8'h00;
         aw_ok_q     <= 1'b0;
         wdata_q     <= 32'h0;
         wstrb_q     <= 4'h0;
         bvalid_q    <= 1'b0;
         bresp_q     <= RESP_OKAY;
         arready_q   <= 1'b0;
         rvalid_q    <= 1'b0;
         rdata_q     <= 32'h0;
         rresp_q     <= RESP_OKAY;
         hdr_ctrl_q  <= RST_HDR_CTRL_B;
         pre_len_q   <= RST_PRE_LEN;
         pre_det_a_q <= RST_PRE_DET_A;
         sync_word_q <= RST_SYNC_WORD;
         irq_stat_q  <= '0;
         irq_mask_q  <= '0;
         control_q   <= 3'h0;
         irq_q       <= 1'b0;
      end else begin
         awready_q   <= awready_d;
         wready_q    <= wready_d;
         aw_got_q    <= aw_got_d;
         w_got_q     <= w_got_d;
         aw_idx_q    <= aw_idx_d;
         aw_ok_q     <= aw_ok_d;
         wdata_q     <= wdata_d;
         wstrb_q     <= wstrb_d;
         bvalid_q    <= bvalid_d;
         bresp_q     <= bresp_d;
         arready_q   <= arready_d;
         rvalid_q    <= rvalid_d;
         rdata_q     <= rdata_d;
         rresp_q     <= rresp_d;
         hdr_ctrl_q  <= hdr_ctrl_d;
         pre_len_q   <= pre_len_d;
         pre_det_a_q <= pre_det_a_d;
         sync_word_q <= sync_word_d;
         irq_stat_q  <= irq_stat_d;
         irq_mask_q  <= irq_mask_d;
         control_q   <= control_d;
         irq_q       <= irq_d;
      end
   end

   assign S_AXI_AWREADY     = awready_q;
   assign S_AXI_WREADY      = wready_q;
   assign S_AXI_BVALID      = bvalid_q;
   assign S_AXI_BRESP       = bresp_q;
   assign S_AXI_ARREADY     = arready_q;
   assign S_AXI_RVALID      = rvalid_q;
   assign S_AXI_RDATA       = rdata_q;
   assign S_AXI_RRESP       = rresp_q;
   assign O_TX_PREAMBLE_LEN = cfg.prealen;
   assign O_GPIO            = gpio_q;
   assign O_IRQ             = irq_q;

endmodule : pds_preamble_sync

// [tb/pds_radio_tx.sv]
/*
 * Far-end transmitter model: drives the demodulated bit and its one-cycle strobe.
 * Assumes its tasks are called one at a time from a single bench process.
 */
module pds_radio_tx (
   input  wire logic i_clk,
   output logic      o_bit,
   output logic      o_valid
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      o_bit = 1'h0;
      o_valid = 1'h0;
   end

   // A gap of zero leaves the strobe up so the next call sends back to back.
   task send(input logic b, input int gap);
      @(posedge i_clk);
      o_bit <= b;
      o_valid <= 1'h1;
      if (gap > 0) begin
         @(posedge i_clk);
         o_valid <= 1'h0;
         o_bit <= ~b;
         repeat (gap - 1) @(posedge i_clk);
      end
   endtask : send

   // The idle line shows the inverse so a stale bit is never read as data.
   task stop();
      @(posedge i_clk);
      o_valid <= 1'h0;
      o_bit <= ~o_bit;
   endtask : stop
endmodule : pds_radio_tx

// [tb/pds_preamble_sync_checker.sv]
/*
 * Port-level checks on the preamble detector and its register bus.
 * Assumes one clock domain and a bind from the bench top file.
 */
module pds_preamble_sync_checker
   import pds_pkg::*;
(
   input wire logic              I_MCLK,
   input wire logic              I_RESETN,
   input wire logic              I_RX_BIT_VALID,
   input wire logic              S_AXI_AWVALID,
   input wire logic              S_AXI_AWREADY,
   input wire logic              S_AXI_WVALID,
   input wire logic              S_AXI_WREADY,
   input wire logic              S_AXI_BVALID,
   input wire logic              S_AXI_BREADY,
   input wire logic [1:0]        S_AXI_BRESP,
   input wire logic              S_AXI_ARVALID,
   input wire logic              S_AXI_ARREADY,
   input wire logic              S_AXI_RVALID,
   input wire logic              S_AXI_RREADY,
   input wire logic [DATA_W-1:0] S_AXI_RDATA,
   input wire logic              O_GPIO,
   input wire logic              O_IRQ
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_RESETN);

   logic wr_hs;
   logic aw_hs;
   assign wr_hs = S_AXI_WVALID && S_AXI_WREADY;
   assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;

   a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped early");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read not answered next cycle");
   a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && wr_hs |=> S_AXI_BVALID)
      else $error("write not answered next cycle");
   a_ar_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read address taken while busy");
   a_aw_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while busy");
   // A write lands at the edge where its later half is taken; the interrupt moves at that
   // edge, the pin one edge later because it decodes the registered control bits.
   a_pin_rise: assert property ($rose(O_GPIO) |-> $past(I_RX_BIT_VALID) || $past(wr_hs, 2) || $past(aw_hs, 2))
      else $error("pin rose without a bit or write");
   // The sync-found pulse drops one cycle after it rose, two cycles after its strobe.
   a_pin_fall: assert property ($fell(O_GPIO) |-> $past(I_RX_BIT_VALID) || $past(I_RX_BIT_VALID, 2) ||
                                $past(wr_hs, 2) || $past(aw_hs, 2))
      else $error("pin fell without a bit or write");
   a_irq_rise: assert property ($rose(O_IRQ) |-> $past(I_RX_BIT_VALID) || $past(wr_hs) || $past(aw_hs))
      else $error("interrupt rose without a cause");
   a_irq_fall: assert property ($fell(O_IRQ) |-> $past(wr_hs) || $past(aw_hs))
      else $error("interrupt fell without a write");
endmodule : pds_preamble_sync_checker

// [tb/pds_preamble_sync_bench.sv]
/*
 * Self-checking bench: register table, detection threshold, timeout and sync search.
 * Assumes the transmitter model and the port checker are compiled before this file.
 */
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module pds_preamble_sync_bench
   import pds_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {logic [11:0] a; logic w; logic [31:0] d; logic [1:0] r;} pds_row_t;
   localparam int TMO = (int'(RST_HDR_CTRL_B[2:1]) + 1) * 8 + 4;
   logic              clk = 1'h0, rst_n = 1'h0, lb = 1'h0, rx_bit, rx_valid;
   logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata, dat;
   logic [3:0]        wstrb = 4'h0;
   logic              awready, wready, bvalid, arready, rvalid, gpio, irq;
   logic [1:0]        bresp, rresp, resp;
   logic [7:0]        txlen;
   int                error_cnt = 0, checks_done = 0, cyc = 0;
   pds_row_t rows [11] = '{'{12'h0cc, 1'h0, 32'h2, RESP_OKAY}, '{12'h0d0, 1'h0, 32'h8, RESP_OKAY},
      '{12'h0d4, 1'h0, 32'h28, RESP_OKAY}, '{12'h0d8, 1'h0, RST_SYNC_WORD, RESP_OKAY},
      '{12'h100, 1'h0, 32'h0, RESP_OKAY}, '{12'h104, 1'h0, 32'h0, RESP_OKAY},
      '{12'h108, 1'h0, 32'h0, RESP_OKAY}, '{12'h0d0, 1'h1, 32'hff, RESP_OKAY},
      '{12'h0d0, 1'h0, 32'hff, RESP_OKAY}, '{12'h3fc, 1'h1, 32'h5, RESP_SLVERR},
      '{12'h3fc, 1'h0, 32'h0, RESP_SLVERR}};

   pds_preamble_sync pds_preamble_sync_inst (
      .I_MCLK(clk), .I_RESETN(rst_n), .I_RX_BIT(rx_bit), .I_RX_BIT_VALID(rx_valid),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .O_TX_PREAMBLE_LEN(txlen), .O_GPIO(gpio), .O_IRQ(irq));
   pds_radio_tx pds_radio_tx_inst (.i_clk(clk), .o_bit(rx_bit), .o_valid(rx_valid));

   initial begin
      forever #5 clk = ~clk;
   end

   task end_sim();
      $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   // The whole run needs well under two thousand cycles.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         $display("watchdog expired at %0t", $time);
         end_sim();
      end
   end

   task axw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      r = bresp;
      bready <= 1'h0;
   endtask : axw

   task axr(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask : axr

   task settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   // With alt low the last bit is repeated, which breaks any alternating run.
   task bits(input int n, input logic alt, input int gap);
      repeat (n) begin
         if (alt) lb = ~lb;
         pds_radio_tx_inst.send(lb, gap);
      end
      pds_radio_tx_inst.stop();
      settle();
   endtask : bits

   initial begin
      repeat (6) @(posedge clk);
      `CHK({gpio, irq}, 2'h0)
      rst_n <= 1'h1;
      $display("test reset done");
      foreach (rows[i]) begin
         if (rows[i].w) axw(rows[i].a, rows[i].d, resp);
         else begin
            axr(rows[i].a, dat, resp);
            `CHK(dat, rows[i].d)
         end
         `CHK(resp, rows[i].r)
      end
      `CHK(txlen, 8'hff)
      $display("test registers done");
      axw(12'h0d4, 32'h8, resp);
      axw(12'h104, 32'h7, resp);
      axw(12'h108, 32'h3, resp);
      settle();
      bits(1, 1'h0, 2);
      bits(2, 1'h1, 2);
      `CHK(gpio, 1'h0)
      bits(1, 1'h1, 0);
      `CHK(gpio, 1'h1)
      $display("test detect done");
      bits(4, 1'h1, 0);
      bits(1, 1'h0, 0);
      bits(TMO - 2, 1'h0, 1);
      `CHK(gpio, 1'h1)
      bits(1, 1'h0, 0);
      `CHK(gpio, 1'h0)
      axr(12'h100, dat, resp);
      `CHK(dat, 32'h5)
      `CHK(irq, 1'h1)
      axw(12'h104, 32'h0, resp);
      settle();
      `CHK(irq, 1'h0)
      axw(12'h104, 32'h7, resp);
      settle();
      `CHK(irq, 1'h1)
      axw(12'h100, 32'h7, resp);
      settle();
      axr(12'h100, dat, resp);
      `CHK({irq, dat}, 33'h0)
      $display("test timeout done");
      axw(12'h0d4, 32'h10, resp);
      bits(1, 1'h0, 0);
      bits(6, 1'h1, 0);
      `CHK(gpio, 1'h0)
      bits(1, 1'h1, 0);
      `CHK(gpio, 1'h1)
      for (int i = 31; i > 16; i--) begin
         lb = RST_SYNC_WORD[i];
         pds_radio_tx_inst.send(lb, 1);
      end
      pds_radio_tx_inst.stop();
      settle();
      `CHK(gpio, 1'h1)
      lb = RST_SYNC_WORD[16];
      bits(1, 1'h0, 0);
      `CHK(gpio, 1'h0)
      axr(12'h100, dat, resp);
      `CHK(dat, 32'h3)
      $display("test sync done");
      // Reset in mid-run: everything written so far must fall back to its reset value.
      rst_n <= 1'h0;
      @(posedge clk);
      `CHK({irq, gpio, arready, txlen}, {3'h0, RST_PRE_LEN})
      rst_n <= 1'h1;
      axr(12'h104, dat, resp);
      `CHK(dat, 32'h0)
      $display("test mid-run reset done");
      axw(12'h0cc, 32'h0, resp);
      axw(12'h0d4, 32'h8, resp);
      axw(12'h108, 32'h5, resp);
      settle();
      lb = 1'h1;
      bits(4, 1'h1, 0);
      `CHK(gpio, 1'h0)
      for (int i = 31; i > 23; i--) begin
         lb = RST_SYNC_WORD[i];
         pds_radio_tx_inst.send(lb, 0);
      end
      pds_radio_tx_inst.stop();
      @(posedge clk);
      `CHK(gpio, 1'h1)
      settle();
      `CHK(gpio, 1'h0)
      lb = 1'h0;
      bits(4, 1'h1, 0);
      bits(11, 1'h0, 0);
      axr(12'h100, dat, resp);
      `CHK(dat, 32'h3)
      bits(1, 1'h0, 0);
      axr(12'h100, dat, resp);
      `CHK(dat, 32'h7)
      $display("test one-byte sync done");
      end_sim();
   end
endmodule : pds_preamble_sync_bench

bind pds_preamble_sync pds_preamble_sync_checker pds_preamble_sync_checker_inst (
   .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_RX_BIT_VALID(I_RX_BIT_VALID), .O_GPIO(O_GPIO), .O_IRQ(O_IRQ),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA));
